// [src/ees_pkg.sv]
// Shared constants and enumerations for the serial memory command port
package ees_pkg;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 100;         // System clock, 10 MHz
  localparam int PROG_TIME_NS  = 10_000_000;  // Longest self-timed cycle, 10 ms
  localparam int CS_LOW_NS     = 250;         // Least chip select low time
  // Longest time rounds down, least time rounds up
  localparam int PROG_CYCLES   = PROG_TIME_NS / CLK_PERIOD_NS;
  localparam int CS_LOW_CYCLES = (CS_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LOWC_W        = $clog2(CS_LOW_CYCLES + 1);

  // ****************************************************************
  // Instruction layout
  // ****************************************************************
  localparam int        CMD_BITS   = 10;      // Opcode plus address after the start bit
  localparam int        WORD_BITS  = 16;
  localparam int        ADDR_BITS  = 8;
  localparam int        DEPTH      = 256;
  localparam logic [1:0] OP_EXT    = 2'h0;
  localparam logic [1:0] OP_WRITE  = 2'h1;
  localparam logic [1:0] OP_READ   = 2'h2;
  localparam logic [1:0] OP_ERASE  = 2'h3;
  localparam logic [1:0] EXT_DIS   = 2'h0;    // program_disable_cmd
  localparam logic [1:0] EXT_FILL  = 2'h1;    // fill_array_cmd
  localparam logic [1:0] EXT_CLEAR = 2'h2;    // clear_array_cmd
  localparam logic [1:0] EXT_EN    = 2'h3;    // program enable
  localparam logic [15:0] ERASED   = 16'hFFFF;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    ST_IDLE,
    ST_CMD,
    ST_DATA,
    ST_ARMED,
    ST_READ,
    ST_IGNORE
  } ees_state_e;

  typedef enum logic [1:0] {
    K_WORD,
    K_FILL,
    K_ERASE,
    K_CLEAR
  } ees_kind_e;

endpackage

// [src/ees_sync.sv]
// Two-flop synchroniser for pin inputs, one chain per bit
`timescale 1ns/1ps
`default_nettype none
module ees_sync #(
  parameter int W = 3
) (
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         ce,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);

  // ****************************************************************
  // Per-bit chains
  // ****************************************************************
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic s1_r;
      logic s2_r;
      // First flop feeds only the second
      always_ff @(posedge clk) begin
        if (rst) begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
        end else if (ce) begin
          s1_r <= d[i];
          s2_r <= s1_r;
        end
      end
      assign q[i] = s2_r;
    end
  endgenerate

endmodule
`default_nettype wire

// [src/ees_port.sv]
// Serial command port and array of a 256 x 16 nonvolatile memory
// Behaviour
// - start bit, two-bit opcode, address, data
// - stopped serial clock holds shift and enable state
// - read loads word, dummy zero first
// - read output changes on clock rise
// - read streams next address, wraps around
// - only read drives data words out
// - power-up leaves programming disabled
// - programming rejected unless enabled
// - enable persists until disable or power-off
// - enable state never affects reads
// - select falling edge starts programming
// - select high after low time shows status
// - select and input high clear status
// - fill programs every word, status alike
// - disable blocks all programming and erase
// - erase clears addressed word, shows status
// - clear array sets every bit one
// - opcodes read, write, erase take address
// - extended codes enable and disable
// - extended codes fill and clear array
// - last sixteen bits form data word
`timescale 1ns/1ps
`default_nettype none
module ees_port #(
  parameter int PROG_CYCLES = ees_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic ce,
  input  wire logic chip_select,
  input  wire logic serial_clock,
  input  wire logic serial_in,
  output logic      serial_out,
  output logic      serial_out_oe_n
);

  localparam int PCW = $clog2(PROG_CYCLES + 1);
  localparam logic [PCW-1:0] PROG_LAST = PCW'(PROG_CYCLES - 1);
  localparam logic [ees_pkg::LOWC_W-1:0] LOW_MET = ees_pkg::LOWC_W'(ees_pkg::CS_LOW_CYCLES);

  typedef struct packed {
    ees_pkg::ees_state_e       state;
    ees_pkg::ees_kind_e        kind;
    logic                      sk_prev;
    logic                      cs_prev;
    logic [3:0]                cnt;
    logic [9:0]                cmd;
    logic [7:0]                addr;
    logic [15:0]               dsh;
    logic                      dany;
    logic [15:0]               osh;
    logic                      wen;
    logic                      busy;
    logic [PCW-1:0]            pcnt;
    logic [ees_pkg::LOWC_W-1:0] lowc;
    logic                      rb;
    logic                      stat;
    logic                      dout;
    logic                      oe_n;
  } ees_st_s;

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [2:0] pins;
  logic       cs_lvl;
  logic       sk_lvl;
  logic       din_lvl;

  ees_sync #(
    .W (3)
  ) u_sync (
    .clk (clk),
    .rst (rst),
    .ce  (ce),
    .d   ({chip_select, serial_clock, serial_in}),
    .q   (pins)
  );
  assign cs_lvl  = pins[2];
  assign sk_lvl  = pins[1];
  assign din_lvl = pins[0];

  // ****************************************************************
  // State and array
  // ****************************************************************
  ees_st_s     r;
  ees_st_s     r_nxt;
  logic [15:0] mem [ees_pkg::DEPTH];
  logic        sk_rise;
  logic        cs_fall;
  logic        cs_rise;
  logic        do_prog;
  logic [9:0]  cmd_full;
  logic [7:0]  addr_inc;

  // Edges come from the synchronised levels only
  assign sk_rise  = sk_lvl && !r.sk_prev;
  assign cs_fall  = !cs_lvl && r.cs_prev;
  assign cs_rise  = cs_lvl && !r.cs_prev;
  assign do_prog  = r.busy && (r.pcnt == '0);
  assign cmd_full = {r.cmd[8:0], din_lvl};
  assign addr_inc = r.addr + 8'h01;

  // Next-state logic for the whole port
  always_comb begin
    r_nxt         = r;
    r_nxt.sk_prev = sk_lvl;
    r_nxt.cs_prev = cs_lvl;

    // Low-time counter saturates so status needs a real low pulse
    if (!cs_lvl && r.lowc != LOW_MET) begin
      r_nxt.lowc = r.lowc + 1'b1;
    end
    if (cs_rise) begin
      r_nxt.lowc = '0;
      if (r.rb && r.lowc == LOW_MET) begin
        r_nxt.stat = 1'b1;
      end
    end

    // Self-timed cycle counts down, array updated at its end
    if (r.busy) begin
      if (do_prog) begin
        r_nxt.busy = 1'b0;
      end else begin
        r_nxt.pcnt = r.pcnt - 1'b1;
      end
    end

    if (cs_fall) begin
      if ((r.state == ees_pkg::ST_DATA && r.dany) || r.state == ees_pkg::ST_ARMED) begin
        r_nxt.busy = 1'b1;
        r_nxt.pcnt = PROG_LAST;
        r_nxt.rb   = 1'b1;
      end
      r_nxt.state = ees_pkg::ST_IDLE;
      r_nxt.stat  = 1'b0;
    end else if (sk_rise && cs_lvl) begin
      if (din_lvl) begin
        r_nxt.stat = 1'b0;
        r_nxt.rb   = 1'b0;
      end
      case (r.state)
        ees_pkg::ST_IDLE: begin
          if (din_lvl) begin
            r_nxt.state = ees_pkg::ST_CMD;
            r_nxt.cnt   = 4'h0;
          end
        end
        ees_pkg::ST_CMD: begin
          r_nxt.cmd = cmd_full;
          r_nxt.cnt = r.cnt + 4'h1;
          if (r.cnt == 4'(ees_pkg::CMD_BITS - 1)) begin
            r_nxt.addr  = cmd_full[7:0];
            r_nxt.dany  = 1'b0;
            r_nxt.state = ees_pkg::ST_IGNORE;
            case (cmd_full[9:8])
              ees_pkg::OP_READ: begin
                r_nxt.state = ees_pkg::ST_READ;
                r_nxt.osh   = mem[cmd_full[7:0]];
                r_nxt.dout  = 1'b0;
                r_nxt.cnt   = 4'h0;
              end
              ees_pkg::OP_WRITE: begin
                r_nxt.kind = ees_pkg::K_WORD;
                if (r.wen) begin
                  r_nxt.state = ees_pkg::ST_DATA;
                end
              end
              ees_pkg::OP_ERASE: begin
                r_nxt.kind = ees_pkg::K_ERASE;
                if (r.wen) begin
                  r_nxt.state = ees_pkg::ST_ARMED;
                end
              end
              default: begin
                case (cmd_full[7:6])
                  ees_pkg::EXT_EN:  r_nxt.wen = 1'b1;
                  ees_pkg::EXT_DIS: r_nxt.wen = 1'b0;
                  ees_pkg::EXT_FILL: begin
                    r_nxt.kind = ees_pkg::K_FILL;
                    if (r.wen) begin
                      r_nxt.state = ees_pkg::ST_DATA;
                    end
                  end
                  default: begin
                    r_nxt.kind = ees_pkg::K_CLEAR;
                    if (r.wen) begin
                      r_nxt.state = ees_pkg::ST_ARMED;
                    end
                  end
                endcase
              end
            endcase
          end
        end
        ees_pkg::ST_DATA: begin
          r_nxt.dsh  = {r.dsh[14:0], din_lvl};
          r_nxt.dany = 1'b1;
        end
        ees_pkg::ST_READ: begin
          r_nxt.dout = r.osh[15];
          r_nxt.osh  = {r.osh[14:0], 1'b0};
          r_nxt.cnt  = r.cnt + 4'h1;
          if (r.cnt == 4'(ees_pkg::WORD_BITS - 1)) begin
            r_nxt.addr = addr_inc;
            r_nxt.osh  = mem[addr_inc];
            r_nxt.cnt  = 4'h0;
          end
        end
        default: begin
        end
      endcase
    end

    // pin driven for read or status only
    if (cs_lvl && r_nxt.state == ees_pkg::ST_READ) begin
      r_nxt.oe_n = 1'b0;
    end else if (cs_lvl && r_nxt.stat && r_nxt.state == ees_pkg::ST_IDLE) begin
      r_nxt.oe_n = 1'b0;
      r_nxt.dout = !r.busy;
    end else begin
      r_nxt.oe_n = 1'b1;
      r_nxt.dout = 1'b0;
    end
  end

  // state moves on every enabled clock
  always_ff @(posedge clk) begin
    if (rst) begin
      r      <= '0;
      r.oe_n <= 1'b1;
    end else if (ce) begin
      r <= r_nxt;
    end
  end

  // Array has no reset: contents survive like the real cells
  always_ff @(posedge clk) begin
    if (ce && do_prog) begin
      for (int i = 0; i < ees_pkg::DEPTH; i++) begin
        if (r.kind == ees_pkg::K_FILL) begin
          mem[i] <= r.dsh;
        end else if (r.kind == ees_pkg::K_CLEAR) begin
          mem[i] <= ees_pkg::ERASED;
        end else if (i == int'(r.addr)) begin
          mem[i] <= (r.kind == ees_pkg::K_WORD) ? r.dsh : ees_pkg::ERASED;
        end
      end
    end
  end

  assign serial_out      = r.dout;
  assign serial_out_oe_n = r.oe_n;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_hold_without_edge;
    !(sk_rise && ce) |=> $stable(r.wen) && $stable(r.cmd) && $stable(r.osh);
  endproperty
  a_hold_without_edge: assert property (p_hold_without_edge)
    else $error("state moved without a serial clock edge");

  property p_prog_needs_enable;
    (r.busy && !$past(r.busy)) |-> $past(r.wen);
  endproperty
  a_prog_needs_enable: assert property (p_prog_needs_enable)
    else $error("programming began while disabled");

  property p_prog_on_cs_fall;
    (r.busy && !$past(r.busy)) |-> $past(cs_fall) && r.pcnt == PROG_LAST;
  endproperty
  a_prog_on_cs_fall: assert property (p_prog_on_cs_fall)
    else $error("programming began without select falling");

  property p_status_value;
    (r.stat && r.state == ees_pkg::ST_IDLE && cs_lvl && !sk_rise && ce)
      |=> (!r.oe_n && r.dout == !$past(r.busy));
  endproperty
  a_status_value: assert property (p_status_value)
    else $error("status pin does not match busy");

  property p_status_clear;
    (cs_lvl && din_lvl && sk_rise && ce) |=> !r.stat && !r.rb;
  endproperty
  a_status_clear: assert property (p_status_clear)
    else $error("status not cleared by select and input high");

  property p_dummy_bit;
    (ce && sk_rise && cs_lvl && r.state == ees_pkg::ST_CMD && r.cnt == 4'h9
      && cmd_full[9:8] == ees_pkg::OP_READ) |=> (!r.oe_n && !r.dout) [*1];
  endproperty
  a_dummy_bit: assert property (p_dummy_bit)
    else $error("read did not open with a driven zero");

  property p_drive_only_read;
    !r.oe_n |-> (r.state == ees_pkg::ST_READ || r.stat);
  endproperty
  a_drive_only_read: assert property (p_drive_only_read)
    else $error("pin driven outside read or status");

  property p_data_needs_enable;
    (r.state == ees_pkg::ST_DATA || r.state == ees_pkg::ST_ARMED) |-> r.wen;
  endproperty
  a_data_needs_enable: assert property (p_data_needs_enable)
    else $error("program instruction accepted while disabled");

  property p_abandon;
    (ce && cs_fall && r.state == ees_pkg::ST_CMD) |=> r.state == ees_pkg::ST_IDLE && !r.busy;
  endproperty
  a_abandon: assert property (p_abandon)
    else $error("partial instruction not abandoned");

  property p_auto_increment;
    (ce && sk_rise && cs_lvl && r.state == ees_pkg::ST_READ && r.cnt == 4'hF)
      |=> r.addr == $past(r.addr) + 8'h01 && r.cnt == 4'h0;
  endproperty
  a_auto_increment: assert property (p_auto_increment)
    else $error("read did not advance to next word");

  c_read_word: cover property (ce && sk_rise && r.state == ees_pkg::ST_READ && r.cnt == 4'hF);
  c_prog_done: cover property (ce && do_prog);
  c_status_ready: cover property (!r.oe_n && r.stat && r.dout);

endmodule
`default_nettype wire

// [testbench/ees_host.sv]
// Host model that drives the serial command pins of the memory port
`timescale 1ns/1ps
`default_nettype none
module ees_host (
  input  wire logic clk,
  output logic      chip_select,
  output logic      serial_clock,
  output logic      serial_in,
  input  wire logic serial_out,
  input  wire logic serial_out_oe_n
);

  // ****************************************************************
  // Pin state
  // ****************************************************************
  // Deselected; the serial clock stands still between frames
  initial begin
    chip_select  = 1'b0;
    serial_clock = 1'b0;
    serial_in    = 1'b1;
  end

  // ****************************************************************
  // Bus cycles
  // ****************************************************************
  // One 800 ns serial clock period; data is set in the low phase so it
  // stays put well past the rise the port samples three clocks late
  // one bit
  task automatic sk_bit(input logic d, output logic q);
    @(posedge clk);
    serial_clock <= 1'b0;
    serial_in    <= d;
    repeat (4) @(posedge clk);
    q = serial_out_oe_n ? 1'h1 : serial_out;  // Released pin reads pulled up
    serial_clock <= 1'b1;
    repeat (3) @(posedge clk);
  endtask

  // Select the port and shift n bits, most significant first
  // start then fields
  task automatic send(input logic [31:0] bits, input int n);
    logic q;
    @(posedge clk);
    chip_select  <= 1'b1;
    serial_clock <= 1'b0;
    for (int i = n - 1; i >= 0; i--) begin
      sk_bit(bits[i], q);
    end
  endtask

  // Drop select while the serial clock is still high, before its next rise
  // select low timing
  task automatic deselect();
    @(posedge clk);
    chip_select <= 1'b0;
    serial_in   <= ~serial_in;  // Released data line shows no stale level
    repeat (5) @(posedge clk);
  endtask

  // Select for status with data held low, so the flag is not cleared
  // polling avoids clear
  task automatic raise_quiet();
    @(posedge clk);
    chip_select <= 1'b1;
    serial_in   <= 1'b0;
  endtask

endmodule
`default_nettype wire

// [testbench/serial_eeprom_command_port_test.sv]
// Self-checking testbench for the serial memory command port
`timescale 1ns/1ps
`default_nettype none
module serial_eeprom_command_port_test;

  // ****************************************************************
  // Clock, reset and wiring
  // ****************************************************************
  logic clk;
  logic rst;
  logic ce;
  logic cs;
  logic sk;
  logic din;
  logic dout;
  logic dout_oe_n;
  int   errors;
  int   checks_done;

  // Short self-timed cycle keeps the run brief
  ees_port #(.PROG_CYCLES(50)) dut_u (
    .clk             (clk),
    .rst             (rst),
    .ce              (ce),
    .chip_select     (cs),
    .serial_clock    (sk),
    .serial_in       (din),
    .serial_out      (dout),
    .serial_out_oe_n (dout_oe_n)
  );

  ees_host host_u (
    .clk             (clk),
    .chip_select     (cs),
    .serial_clock    (sk),
    .serial_in       (din),
    .serial_out      (dout),
    .serial_out_oe_n (dout_oe_n)
  );

  // 10 MHz system clock
  initial begin
    clk = 1'b0;
  end
  always #50 clk = ~clk;

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  // Compare and count
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Raise select and judge the ready/busy indication; a busy that never
  // clears ends the run rather than hanging it
  task automatic status(input logic exp_shown);
    int n;
    host_u.raise_quiet();
    for (n = 0; n < 20 && dout_oe_n === 1'b1; n++) begin
      @(posedge clk);
    end
    check("status shown", {15'h0, ~dout_oe_n}, {15'h0, exp_shown});
    if (dout_oe_n === 1'b0) begin
      check("status busy", {15'h0, dout}, 16'h0000);
      // Next instruction only once ready is seen
      for (n = 0; n < 300 && dout !== 1'b1; n++) begin
        @(posedge clk);
      end
      if (dout !== 1'b1) begin
        errors++;
        $display("BAD status ready expected 1 seen %b", dout);
        summarize();
      end
    end
    host_u.deselect();
  endtask

  // Read two consecutive words with a clock stop after the dummy bit
  task automatic read2(input logic [7:0] a, input logic [15:0] e0, input logic [15:0] e1);
    logic        q;
    logic [15:0] w;
    w = 16'h0000;
    host_u.send({21'h0, 1'h1, 2'h2, a}, 11);
    host_u.sk_bit(1'b0, q);
    check("dummy bit", {15'h0, q}, 16'h0000);
    // Port frozen mid-read must pick up exactly where it stopped
    ce <= 1'b0;
    repeat (40) @(posedge clk);
    ce <= 1'b1;
    for (int k = 0; k < 2; k++) begin
      for (int b = 0; b < 16; b++) begin
        host_u.sk_bit(1'b0, q);
        w = {w[14:0], q};
      end
      check("read word", w, (k == 0) ? e0 : e1);
    end
    host_u.deselect();
  endtask

  // Short instruction without data
  task automatic cmd(input logic [1:0] op, input logic [7:0] a);
    host_u.send({21'h0, 1'h1, op, a}, 11);
    host_u.deselect();
  endtask

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    errors      = 0;
    checks_done = 0;
    rst         = 1'b1;
    ce          = 1'b1;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    check("idle enable", {15'h0, dout_oe_n}, 16'h0001);

    // Write straight after power-up is refused
    host_u.send({5'h0, 1'h1, 2'h1, 8'h03, 16'h5555}, 27);
    host_u.deselect();
    status(1'b0);

    // Enable, clear the array, read across the top address
    cmd(2'h0, 8'hC0);
    cmd(2'h0, 8'h80);
    status(1'b1);
    read2(8'hFF, 16'hFFFF, 16'hFFFF);

    // Single word write then read back with its neighbour
    host_u.send({5'h0, 1'h1, 2'h1, 8'h03, 16'h1234}, 27);
    host_u.deselect();
    status(1'b1);
    read2(8'h03, 16'h1234, 16'hFFFF);

    // Disabled: writes blocked, reads still served
    cmd(2'h0, 8'h00);
    host_u.send({5'h0, 1'h1, 2'h1, 8'h03, 16'h5A5A}, 27);
    host_u.deselect();
    status(1'b0);
    read2(8'h02, 16'hFFFF, 16'h1234);

    // Fill with twenty data bits; only the last sixteen count
    cmd(2'h0, 8'hFF);
    host_u.send({1'h0, 1'h1, 2'h0, 8'h40, 20'hABEEF}, 31);
    host_u.deselect();
    status(1'b1);
    read2(8'hFE, 16'hBEEF, 16'hBEEF);

    // Erase one word while enable persists
    cmd(2'h3, 8'h05);
    status(1'b1);
    read2(8'h04, 16'hBEEF, 16'hFFFF);

    // Select dropped mid-instruction, then a clean read
    host_u.send({27'h0, 1'h1, 2'h1, 2'h0}, 5);
    host_u.deselect();
    status(1'b0);
    read2(8'h04, 16'hBEEF, 16'hFFFF);
    summarize();
  end

endmodule
`default_nettype wire
